// file: shared/chg_defines.svh
// Bus address, register offsets, reset values and timing figures of the charger register bank.
//
// What this block does
// - Answer as bus slave at address 0x53
// - Read-only ignores writes; reserved bits read zero
// - Boost voltage limit, default 5.15V, keeps on watchdog
// - Low-battery cutoff bit: 0 2.8V, 1 2.5V
// - Boost current limit bit 0, default 1.2A
// - Long press 10s turns battery switch off
// - Bit 3 disables bus hang time-out
// - Watchdog restart bit restarts count, self-clears
// - Watchdog period: off, 40s, 80s, 160s
// - Battery switch off bit, hardware set/clear
// - Switch-off delay bit gives 12s delay
// - High-impedance bit, cleared by supply plug-in
// - Boost enable cleared by listed fault events
// - Register 0x02 bit 0 enables charging
// - Optimizer start bit self-clears when complete
// - Auto select overwrites input current limit
// - Input current limit code, default 500mA
// - Overvoltage level limited to 6.35V during boost
// - Input voltage tracking adds battery offset
// - Minimum input voltage code, default 4500mV
// - Pre-charge voltage and current codes
`ifndef CHG_DEFINES_SVH
`define CHG_DEFINES_SVH

// ---------------------------------------------------------------
// Bus address and register offsets.
// ---------------------------------------------------------------
`define CHG_SLAVE_ADDR      7'h53
`define CHG_REG_BOOST       8'h00
`define CHG_REG_TOP         8'h01
`define CHG_REG_FUNC        8'h02
`define CHG_REG_INPUT_CURRENT_CONTROL        8'h03
`define CHG_REG_INPUT_VOLTAGE_CONTROL        8'h04
`define CHG_REG_PRECHARGE_SETTINGS      8'h05

// ---------------------------------------------------------------
// Field reset values.
// ---------------------------------------------------------------
`define CHG_RST_BOOST_V     2'h2
`define CHG_RST_BOOST_LBP   1'h0
`define CHG_RST_BOOST_CC    1'h1
`define CHG_RST_LONG_EN     1'h1
`define CHG_RST_STAT_EN     1'h1
`define CHG_RST_TO_DIS      1'h0
`define CHG_RST_WD_PERIOD   2'h1
`define CHG_RST_SW_OFF      1'h0
`define CHG_RST_OFF_DLY     1'h1
`define CHG_RST_HIZ         1'h0
`define CHG_RST_PFM_DIS     1'h0
`define CHG_RST_FORCE_ON    1'h0
`define CHG_RST_BOOST_EN    1'h0
`define CHG_RST_CHARGING_ALLOW      1'h1
`define CHG_RST_OPT_START   1'h0
`define CHG_RST_AUTO_SEL    1'h1
`define CHG_RST_ICL         6'h0a
`define CHG_RST_OVP         2'h1
`define CHG_RST_TRACK       2'h0
`define CHG_RST_VMIN        4'h6
`define CHG_RST_PRE_V       3'h4
`define CHG_RST_PRE_I       4'h2
// Overvoltage code that the higher codes fall back to during boost.
`define CHG_OVP_BOOST_CAP   2'h1

// ---------------------------------------------------------------
// Timing figures.
// ---------------------------------------------------------------
`define CHG_CLK_PERIOD_NS   8
`define CHG_NS_PER_MS       1000000
`define CHG_LONG_PRESS_MS   10000
`define CHG_SHORT_PRESS_MS  1000
`define CHG_OFF_DELAY_MS    12000

`endif

// file: shared/chg_pkg.sv
// Types shared by the charger register bank.
package chg_pkg;

	// All configuration fields of registers 0x00 to 0x05.
	typedef struct packed {
		logic [1:0] boost_voltage_limit;
		logic       boost_low_battery_cutoff;
		logic       boost_current_limit;
		logic       long_press_enable;
		logic       status_pin_enable;
		logic       bus_timeout_disable;
		logic       watchdog_count_restart;
		logic [1:0] watchdog_period;
		logic       battery_switch_off;
		logic       switch_off_delay;
		logic       high_impedance_input;
		logic       pfm_disable;
		logic       blocking_switch_force_on;
		logic       boost_output_enable;
		logic       charging_allow;
		logic       input_current_optimizer_start;
		logic       auto_input_limit_select;
		logic [5:0] input_current_limit;
		logic [1:0] input_overvoltage_level;
		logic [1:0] input_voltage_tracking;
		logic [3:0] min_input_voltage;
		logic [2:0] precharge_voltage;
		logic [3:0] precharge_current;
	} chg_cfg_type;

	// Hardware events that set or clear self-changing fields.
	typedef struct packed {
		logic       supply_plug_in;
		logic       system_overload;
		logic       over_temperature;
		logic       low_battery;
		logic       input_overvoltage;
		logic       hiccup_fail;
		logic       optimizer_done;
		logic       auto_limit_valid;
		logic [5:0] auto_limit_code;
		logic       watchdog_expired;
		logic       register_reset;
	} chg_evt_type;

	// Serial slave phases.
	typedef enum logic [2:0] {
		CHG_ST_IDLE,
		CHG_ST_ADDR,
		CHG_ST_REG,
		CHG_ST_WDATA,
		CHG_ST_RDATA
	} chg_state_type;

endpackage

// file: rtl/chg_regbank.sv
// Charger control register bank with its serial slave port and power-switch timing.
`timescale 1ns/1ps
`include "chg_defines.svh"

module chg_regbank import chg_pkg::*; #(
	parameter int MS_CYCLES      = `CHG_NS_PER_MS / `CHG_CLK_PERIOD_NS,
	parameter int LONG_PRESS_MS  = `CHG_LONG_PRESS_MS,
	parameter int SHORT_PRESS_MS = `CHG_SHORT_PRESS_MS,
	parameter int OFF_DELAY_MS   = `CHG_OFF_DELAY_MS
) (
	input  wire logic        clk,
	input  wire logic        rst_n,
	input  wire logic        scl_in,
	input  wire logic        sda_in,
	output logic             sda_out,
	output logic             sda_oe,
	input  wire logic        power_button_pin_n,
	input  wire chg_evt_type evt,
	output chg_cfg_type      cfg_q,
	output logic [1:0]       ovp_level_q,
	output logic             battery_switch_on_q,
	output logic             watchdog_restart_q
);

	// ---------------------------------------------------------------
	// Parameter checks.
	// ---------------------------------------------------------------
	// Counters below are sized for these ranges; refuse anything else.
	if (MS_CYCLES < 1 || MS_CYCLES > 262143 || SHORT_PRESS_MS < 1 || LONG_PRESS_MS <= SHORT_PRESS_MS ||
		LONG_PRESS_MS > 16383 || OFF_DELAY_MS < 1 || OFF_DELAY_MS > 16383) begin
		$error("chg_regbank: timing parameters out of range");
	end

	// ---------------------------------------------------------------
	// Pin synchronisers.
	// ---------------------------------------------------------------
	logic [2:0] scl_sync_q;    // Two sync stages plus one history stage.
	logic [2:0] sda_sync_q;    // Two sync stages plus one history stage.
	logic [1:0] btn_sync_q;    // Button pin, two sync stages.

	// The first stage of each chain feeds only the second stage.
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			scl_sync_q <= 3'h7;
			sda_sync_q <= 3'h7;
			btn_sync_q <= 2'h3;
		end else begin
			scl_sync_q <= {scl_sync_q[1:0], scl_in};
			sda_sync_q <= {sda_sync_q[1:0], sda_in};
			btn_sync_q <= {btn_sync_q[0], power_button_pin_n};
		end
	end

	logic scl_rise;    // Clock line went high.
	logic scl_fall;    // Clock line went low.
	logic bus_start;   // Data fell while clock high.
	logic bus_stop;    // Data rose while clock high.
	logic sda_now;     // Settled data line level.

	assign sda_now   = sda_sync_q[1];
	assign scl_rise  = scl_sync_q[1] & ~scl_sync_q[2];
	assign scl_fall  = ~scl_sync_q[1] & scl_sync_q[2];
	assign bus_start = scl_sync_q[1] & scl_sync_q[2] & ~sda_sync_q[1] & sda_sync_q[2];
	assign bus_stop  = scl_sync_q[1] & scl_sync_q[2] & sda_sync_q[1] & ~sda_sync_q[2];

	// ---------------------------------------------------------------
	// Read mux.
	// ---------------------------------------------------------------
	// Reserved bits and unmapped addresses read as zero.
	function automatic logic [7:0] read_byte(input logic [7:0] a, input chg_cfg_type c);
		logic [7:0] r;
		r = 8'h00;
		case (a)
			`CHG_REG_BOOST:  r = {c.boost_voltage_limit, 4'h0, c.boost_low_battery_cutoff,
				c.boost_current_limit};
			`CHG_REG_TOP:    r = {c.long_press_enable, c.status_pin_enable, 2'h0, c.bus_timeout_disable,
				c.watchdog_count_restart, c.watchdog_period};
			`CHG_REG_FUNC:   r = {c.battery_switch_off, c.switch_off_delay, c.high_impedance_input, 1'h0,
				c.pfm_disable, c.blocking_switch_force_on, c.boost_output_enable, c.charging_allow};
			`CHG_REG_INPUT_CURRENT_CONTROL:   r = {c.input_current_optimizer_start, c.auto_input_limit_select,
				c.input_current_limit};
			`CHG_REG_INPUT_VOLTAGE_CONTROL:   r = {c.input_overvoltage_level, c.input_voltage_tracking, c.min_input_voltage};
			`CHG_REG_PRECHARGE_SETTINGS: r = {1'h0, c.precharge_voltage, c.precharge_current};
			default:         r = 8'h00;
		endcase
		return r;
	endfunction

	// ---------------------------------------------------------------
	// Serial slave.
	// ---------------------------------------------------------------
	chg_state_type st_q, st_d;           // Transfer phase.
	logic [3:0]    bit_cnt_q, bit_cnt_d; // Bits clocked in the current byte.
	logic          in_ack_q, in_ack_d;   // Inside the acknowledge slot.
	logic [7:0]    shift_q, shift_d;     // Incoming byte.
	logic [7:0]    tx_q, tx_d;           // Outgoing byte.
	logic [7:0]    ptr_q, ptr_d;         // Register pointer.
	logic          rw_q, rw_d;           // Read transfer selected.
	logic          nack_q, nack_d;       // Host refused further read data.
	logic          oe_q, oe_d;           // Pulling the data line low.
	logic          wr_en;                // One-cycle register write strobe.
	logic [7:0]    rd_now;               // Byte at the pointer.

	assign rd_now = read_byte(ptr_q, cfg_q);

	// Bits are sampled on clock rise and the data line changes only after clock fall.
	always_comb begin
		st_d      = st_q;
		bit_cnt_d = bit_cnt_q;
		in_ack_d  = in_ack_q;
		shift_d   = shift_q;
		tx_d      = tx_q;
		ptr_d     = ptr_q;
		rw_d      = rw_q;
		nack_d    = nack_q;
		oe_d      = oe_q;
		wr_en     = 1'b0;
		if (bus_start) begin
			// A repeated start also lands here and keeps the pointer.
			st_d      = CHG_ST_ADDR;
			bit_cnt_d = 4'h0;
			in_ack_d  = 1'b0;
			oe_d      = 1'b0;
		end else if (bus_stop) begin
			st_d = CHG_ST_IDLE;
			oe_d = 1'b0;
		end else if (st_q != CHG_ST_IDLE && scl_rise) begin
			if (!in_ack_q) begin
				shift_d   = {shift_q[6:0], sda_now};
				bit_cnt_d = bit_cnt_q + 4'h1;
			end else if (st_q == CHG_ST_RDATA) begin
				nack_d = sda_now;
			end
		end else if (st_q != CHG_ST_IDLE && scl_fall) begin
			if (!in_ack_q && bit_cnt_q == 4'h8) begin
				// A whole byte is in; open the acknowledge slot.
				in_ack_d = 1'b1;
				oe_d     = 1'b1;
				case (st_q)
					CHG_ST_ADDR: begin
						if (shift_q[7:1] == `CHG_SLAVE_ADDR) begin
							rw_d = shift_q[0];
						end else begin
							st_d = CHG_ST_IDLE;
							oe_d = 1'b0;
						end
					end
					CHG_ST_REG: begin
						ptr_d = shift_q;
					end
					CHG_ST_WDATA: begin
						wr_en = 1'b1;
						ptr_d = ptr_q + 8'h01;
					end
					CHG_ST_RDATA: begin
						oe_d = 1'b0;
					end
					default: begin
						oe_d = 1'b0;
					end
				endcase
			end else if (in_ack_q) begin
				// Acknowledge slot is over; start the next byte.
				in_ack_d  = 1'b0;
				bit_cnt_d = 4'h0;
				oe_d      = 1'b0;
				case (st_q)
					CHG_ST_ADDR:  st_d = rw_q ? CHG_ST_RDATA : CHG_ST_REG;
					CHG_ST_REG:   st_d = CHG_ST_WDATA;
					CHG_ST_WDATA: st_d = CHG_ST_WDATA;
					CHG_ST_RDATA: st_d = nack_q ? CHG_ST_IDLE : CHG_ST_RDATA;
					default:      st_d = CHG_ST_IDLE;
				endcase
				if ((st_q == CHG_ST_ADDR && rw_q) || (st_q == CHG_ST_RDATA && !nack_q)) begin
					tx_d  = rd_now;
					ptr_d = ptr_q + 8'h01;
					oe_d  = ~rd_now[7];
				end
			end else if (st_q == CHG_ST_RDATA) begin
				// Present the next bit, most significant first.
				tx_d = {tx_q[6:0], 1'b0};
				oe_d = ~tx_q[6];
			end
		end
	end

	// Phase registers of the serial slave.
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			st_q      <= CHG_ST_IDLE;
			bit_cnt_q <= 4'h0;
			in_ack_q  <= 1'b0;
			shift_q   <= 8'h00;
			tx_q      <= 8'h00;
			ptr_q     <= 8'h00;
			rw_q      <= 1'b0;
			nack_q    <= 1'b0;
			oe_q      <= 1'b0;
		end else begin
			st_q      <= st_d;
			bit_cnt_q <= bit_cnt_d;
			in_ack_q  <= in_ack_d;
			shift_q   <= shift_d;
			tx_q      <= tx_d;
			ptr_q     <= ptr_d;
			rw_q      <= rw_d;
			nack_q    <= nack_d;
			oe_q      <= oe_d;
		end
	end

	// The line is open drain: only ever driven low.
	assign sda_oe  = oe_q;
	assign sda_out = 1'b0;

	// ---------------------------------------------------------------
	// Millisecond tick and button timing.
	// ---------------------------------------------------------------
	logic [17:0] div_q, div_d;       // Divider toward the millisecond tick.
	logic        ms_tick;            // One-cycle pulse each millisecond.
	logic [13:0] press_q, press_d;   // Milliseconds the button has been held.
	logic        short_press;        // Button held for the short time.
	logic        long_press;         // Button held for the long time with the feature enabled.

	assign ms_tick     = (div_q == 18'(MS_CYCLES - 1));
	assign short_press = ms_tick && !btn_sync_q[1] && press_q == 14'(SHORT_PRESS_MS - 1);
	assign long_press  = ms_tick && !btn_sync_q[1] && press_q == 14'(LONG_PRESS_MS - 1) &&
		cfg_q.long_press_enable;

	// The press counter stops at the long time so a held button fires once.
	always_comb begin
		div_d   = ms_tick ? 18'h0 : div_q + 18'h1;
		press_d = press_q;
		if (btn_sync_q[1]) begin
			press_d = 14'h0;
		end else if (ms_tick && press_q != 14'(LONG_PRESS_MS)) begin
			press_d = press_q + 14'h1;
		end
	end

	// Divider and press counter registers.
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			div_q   <= 18'h0;
			press_q <= 14'h0;
		end else begin
			div_q   <= div_d;
			press_q <= press_d;
		end
	end

	// ---------------------------------------------------------------
	// Register fields.
	// ---------------------------------------------------------------
	chg_cfg_type cfg_d;       // Next field values.
	logic [7:0]  wd;          // Written byte.
	logic        wr_restart;  // Watchdog restart pulse toward the timer.

	// Order: resets, then host write, then hardware; hardware set beats a host clear.
	always_comb begin
		wd         = shift_q;
		cfg_d      = cfg_q;
		wr_restart = 1'b0;
		// The restart bit lives one cycle and then returns to zero.
		if (cfg_q.watchdog_count_restart) begin
			cfg_d.watchdog_count_restart = 1'b0;
			wr_restart                   = 1'b1;
		end
		if (evt.register_reset) begin
			cfg_d = '{`CHG_RST_BOOST_V, `CHG_RST_BOOST_LBP, `CHG_RST_BOOST_CC, `CHG_RST_LONG_EN,
				`CHG_RST_STAT_EN, `CHG_RST_TO_DIS, 1'b0, `CHG_RST_WD_PERIOD, `CHG_RST_SW_OFF,
				`CHG_RST_OFF_DLY, `CHG_RST_HIZ, `CHG_RST_PFM_DIS, `CHG_RST_FORCE_ON, `CHG_RST_BOOST_EN,
				`CHG_RST_CHARGING_ALLOW, `CHG_RST_OPT_START, `CHG_RST_AUTO_SEL, `CHG_RST_ICL, `CHG_RST_OVP,
				`CHG_RST_TRACK, `CHG_RST_VMIN, `CHG_RST_PRE_V, `CHG_RST_PRE_I};
		end else if (evt.watchdog_expired) begin
			// Only fields flagged for watchdog reset; voltage limit and the rest keep.
			cfg_d.boost_current_limit           = `CHG_RST_BOOST_CC;
			cfg_d.long_press_enable             = `CHG_RST_LONG_EN;
			cfg_d.bus_timeout_disable           = `CHG_RST_TO_DIS;
			cfg_d.watchdog_count_restart        = 1'b0;
			cfg_d.watchdog_period               = `CHG_RST_WD_PERIOD;
			cfg_d.high_impedance_input          = `CHG_RST_HIZ;
			cfg_d.boost_output_enable           = `CHG_RST_BOOST_EN;
			cfg_d.charging_allow                = `CHG_RST_CHARGING_ALLOW;
			cfg_d.input_current_optimizer_start = `CHG_RST_OPT_START;
			cfg_d.auto_input_limit_select       = `CHG_RST_AUTO_SEL;
			cfg_d.precharge_voltage             = `CHG_RST_PRE_V;
			cfg_d.precharge_current             = `CHG_RST_PRE_I;
		end else if (wr_en) begin
			case (ptr_q)
				`CHG_REG_BOOST: begin
					cfg_d.boost_voltage_limit      = wd[7:6];
					cfg_d.boost_low_battery_cutoff = wd[1];
					cfg_d.boost_current_limit      = wd[0];
				end
				`CHG_REG_TOP: begin
					cfg_d.long_press_enable      = wd[7];
					cfg_d.status_pin_enable      = wd[6];
					cfg_d.bus_timeout_disable    = wd[3];
					cfg_d.watchdog_count_restart = wd[2];
					cfg_d.watchdog_period        = wd[1:0];
				end
				`CHG_REG_FUNC: begin
					cfg_d.battery_switch_off       = wd[7];
					cfg_d.switch_off_delay         = wd[6];
					cfg_d.high_impedance_input     = wd[5];
					cfg_d.pfm_disable              = wd[3];
					cfg_d.blocking_switch_force_on = wd[2];
					cfg_d.boost_output_enable      = wd[1];
					cfg_d.charging_allow           = wd[0];
				end
				`CHG_REG_INPUT_CURRENT_CONTROL: begin
					cfg_d.input_current_optimizer_start = wd[7];
					cfg_d.auto_input_limit_select       = wd[6];
					cfg_d.input_current_limit           = wd[5:0];
				end
				`CHG_REG_INPUT_VOLTAGE_CONTROL: begin
					cfg_d.input_overvoltage_level = wd[7:6];
					cfg_d.input_voltage_tracking  = wd[5:4];
					cfg_d.min_input_voltage       = wd[3:0];
				end
				`CHG_REG_PRECHARGE_SETTINGS: begin
					cfg_d.precharge_voltage = wd[6:4];
					cfg_d.precharge_current = wd[3:0];
				end
				default: begin
					// Unmapped and read-only locations swallow the write.
					cfg_d = cfg_d;
				end
			endcase
		end
		// Hardware changes to self-changing fields.
		if (evt.supply_plug_in || short_press) begin
			cfg_d.battery_switch_off = 1'b0;
		end
		if (evt.supply_plug_in) begin
			cfg_d.high_impedance_input = 1'b0;
		end
		if (evt.system_overload || long_press) begin
			cfg_d.battery_switch_off = 1'b1;
		end
		if (evt.optimizer_done) begin
			cfg_d.input_current_optimizer_start = 1'b0;
		end
		if (evt.auto_limit_valid && cfg_q.auto_input_limit_select) begin
			cfg_d.input_current_limit = evt.auto_limit_code;
		end
		if (cfg_d.high_impedance_input || evt.over_temperature || evt.low_battery || evt.input_overvoltage ||
			long_press || cfg_d.battery_switch_off || evt.hiccup_fail) begin
			cfg_d.boost_output_enable = 1'b0;
		end
	end

	// Field registers.
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			cfg_q <= '{`CHG_RST_BOOST_V, `CHG_RST_BOOST_LBP, `CHG_RST_BOOST_CC, `CHG_RST_LONG_EN,
				`CHG_RST_STAT_EN, `CHG_RST_TO_DIS, 1'b0, `CHG_RST_WD_PERIOD, `CHG_RST_SW_OFF,
				`CHG_RST_OFF_DLY, `CHG_RST_HIZ, `CHG_RST_PFM_DIS, `CHG_RST_FORCE_ON, `CHG_RST_BOOST_EN,
				`CHG_RST_CHARGING_ALLOW, `CHG_RST_OPT_START, `CHG_RST_AUTO_SEL, `CHG_RST_ICL, `CHG_RST_OVP,
				`CHG_RST_TRACK, `CHG_RST_VMIN, `CHG_RST_PRE_V, `CHG_RST_PRE_I};
			watchdog_restart_q <= 1'b0;
		end else begin
			cfg_q              <= cfg_d;
			watchdog_restart_q <= wr_restart;
		end
	end

	// ---------------------------------------------------------------
	// Battery switch and effective overvoltage level.
	// ---------------------------------------------------------------
	logic [13:0] off_cnt_q, off_cnt_d;   // Milliseconds waited before switching off.
	logic        sw_on_d;                // Next switch state.
	logic [1:0]  ovp_d;                  // Level handed to the protection comparator.

	// The delay restarts whenever the off request is withdrawn.
	always_comb begin
		off_cnt_d = off_cnt_q;
		sw_on_d   = battery_switch_on_q;
		if (long_press) begin
			sw_on_d = 1'b0;
		end else if (!cfg_q.battery_switch_off) begin
			off_cnt_d = 14'h0;
			sw_on_d   = 1'b1;
		end else if (!cfg_q.switch_off_delay) begin
			sw_on_d = 1'b0;
		end else if (off_cnt_q == 14'(OFF_DELAY_MS)) begin
			sw_on_d = 1'b0;
		end else if (ms_tick) begin
			off_cnt_d = off_cnt_q + 14'h1;
		end
		ovp_d = cfg_q.input_overvoltage_level;
		if (cfg_q.boost_output_enable && cfg_q.input_overvoltage_level > `CHG_OVP_BOOST_CAP) begin
			ovp_d = `CHG_OVP_BOOST_CAP;
		end
	end

	// Switch and level registers.
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			off_cnt_q           <= 14'h0;
			battery_switch_on_q <= 1'b1;
			ovp_level_q         <= `CHG_RST_OVP;
		end else begin
			off_cnt_q           <= off_cnt_d;
			battery_switch_on_q <= sw_on_d;
			ovp_level_q         <= ovp_d;
		end
	end

endmodule

// file: tb/chg_regbank_asserts.sv
// Port assertions for the charger register bank.
`timescale 1ns/1ps
module chg_regbank_asserts import chg_pkg::*; (
	input wire logic        clk,
	input wire logic        rst_n,
	input wire logic        sda_out,
	input wire chg_evt_type evt,
	input wire chg_cfg_type cfg_q,
	input wire logic [1:0]  ovp_level_q,
	input wire logic        battery_switch_on_q,
	input wire logic        watchdog_restart_q
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);
	// The restart bit drops back while the outward pulse is given.
	sequence s_restart;
		!cfg_q.watchdog_count_restart && watchdog_restart_q;
	endsequence
	property p_open_drain; sda_out == 1'b0; endproperty
	property p_restart; $rose(cfg_q.watchdog_count_restart) |=> s_restart; endproperty
	property p_ovp;
		1'b1 |=> ovp_level_q == (($past(cfg_q.boost_output_enable) && $past(cfg_q.input_overvoltage_level[1]))
			? 2'h1 : $past(cfg_q.input_overvoltage_level));
	endproperty
	property p_off_boost; cfg_q.battery_switch_off |-> !cfg_q.boost_output_enable; endproperty
	property p_plug;
		evt.supply_plug_in && !evt.system_overload |=> !cfg_q.high_impedance_input && !cfg_q.battery_switch_off;
	endproperty
	property p_overload; evt.system_overload |=> cfg_q.battery_switch_off; endproperty
	property p_opt; evt.optimizer_done |=> !cfg_q.input_current_optimizer_start; endproperty
	property p_auto;
		evt.auto_limit_valid && cfg_q.auto_input_limit_select && !evt.register_reset
			|=> cfg_q.input_current_limit == $past(evt.auto_limit_code);
	endproperty
	property p_regrst; $onehot(evt) && evt.register_reset |=> cfg_q == 40'h9c50a52342; endproperty
	property p_wdt;
		$onehot(evt) && evt.watchdog_expired |=> cfg_q.watchdog_period == 2'h1
			&& cfg_q.boost_voltage_limit == $past(cfg_q.boost_voltage_limit);
	endproperty
	property p_now; cfg_q.battery_switch_off && !cfg_q.switch_off_delay |=> !battery_switch_on_q; endproperty
	a_open_drain: assert property (p_open_drain) else $error("data line driven high");
	a_restart: assert property (p_restart) else $error("restart bit or pulse wrong");
	a_ovp: assert property (p_ovp) else $error("effective overvoltage code wrong");
	a_off_boost: assert property (p_off_boost) else $error("boost on while switch off");
	a_plug: assert property (p_plug) else $error("plug-in did not clear bits");
	a_overload: assert property (p_overload) else $error("overload did not set switch off");
	a_opt: assert property (p_opt) else $error("optimizer start not cleared");
	a_auto: assert property (p_auto) else $error("auto limit not taken");
	a_regrst: assert property (p_regrst) else $error("register reset values wrong");
	a_wdt: assert property (p_wdt) else $error("watchdog expiry values wrong");
	a_now: assert property (p_now) else $error("switch not off at once");
endmodule
bind chg_regbank chg_regbank_asserts u_asserts (.clk(clk), .rst_n(rst_n), .sda_out(sda_out), .evt(evt),
	.cfg_q(cfg_q), .ovp_level_q(ovp_level_q), .battery_switch_on_q(battery_switch_on_q),
	.watchdog_restart_q(watchdog_restart_q));

// file: tb/chg_host_model.sv
// Host model: a bus master that reads and writes the charger registers.
`timescale 1ns/1ps
`include "chg_defines.svh"
module chg_host_model (
	input  wire logic clk,
	output logic      scl,
	output logic      sda_low,
	input  wire logic sda_line
);
	// Both lines start released to their pull-ups.
	initial begin
		scl = 1'b1;
		sda_low = 1'b0;
	end
	// Six clocks per phase, well above the four the slave needs.
	task automatic hold();
		repeat (6) @(posedge clk);
	endtask
	// Sets data, raises the clock, then moves data while it is high.
	task automatic cond(input logic s0, input logic s1);
		sda_low <= s0;
		hold();
		scl <= 1'b1;
		hold();
		sda_low <= s1;
		hold();
	endtask
	task automatic start();
		cond(1'b0, 1'b1);
		scl <= 1'b0;
		hold();
	endtask
	task automatic bitx(input logic b, output logic g);
		sda_low <= !b;
		hold();
		scl <= 1'b1;
		hold();
		g = sda_line;
		scl <= 1'b0;
		hold();
	endtask
	// One byte, most significant bit first, then the acknowledge slot.
	task automatic xfer(input logic [7:0] tx, input logic last, output logic [7:0] rx, output logic ack);
		logic g;
		for (int i = 7; i >= 0; i--) begin
			bitx(tx[i], g);
			rx[i] = g;
		end
		bitx(last, g);
		ack = !g;
	endtask
	task automatic wr(input logic [6:0] dev, input logic [7:0] r, input logic [7:0] d, output logic ack);
		logic [7:0] x;
		logic       a;
		start();
		xfer({dev, 1'b0}, 1'b1, x, ack);
		if (ack) begin
			xfer(r, 1'b1, x, a);
			xfer(d, 1'b1, x, a);
		end
		cond(1'b1, 1'b0);
	endtask
	task automatic rd(input logic [7:0] r, output logic [7:0] d);
		logic [7:0] x;
		logic       a;
		start();
		xfer({`CHG_SLAVE_ADDR, 1'b0}, 1'b1, x, a);
		xfer(r, 1'b1, x, a);
		start();
		xfer({`CHG_SLAVE_ADDR, 1'b1}, 1'b1, x, a);
		xfer(8'hff, 1'b1, d, a);
		cond(1'b1, 1'b0);
	endtask
endmodule

// file: tb/tb_chg_regbank.sv
// Self-checking bench for the charger register bank.
`timescale 1ns/1ps
`include "chg_defines.svh"
`define CHK(n, e, g) begin num_checks++; if ((g) !== (e)) begin failures++; \
	$display("mismatch %s exp %h got %h", n, e, g); end end
module tb_chg_regbank import chg_pkg::*;;
	logic        clk = 1'b0;
	logic        rst_n = 1'b0;
	logic        btn_n = 1'b1;
	chg_evt_type evt = '0;
	chg_cfg_type cfg;
	logic [1:0]  ovp;
	logic        on;
	logic        scl;
	logic        sda_low;
	logic        sda_oe;
	logic        sda_out;
	logic        ack;
	int          failures = 0;
	int          num_checks = 0;
	// Register images after reset, after writing all ones and after a watchdog expiry.
	logic [7:0]  dft [6] = '{8'h81, 8'hc1, 8'h41, 8'h4a, 8'h46, 8'h42};
	logic [7:0]  ones [7] = '{8'hc3, 8'hcb, 8'hed, 8'hff, 8'hff, 8'h7f, 8'h00};
	logic [7:0]  wd [6] = '{8'hc3, 8'hc1, 8'h41, 8'h55, 8'hff, 8'h42};
	wire         sda_line = !(sda_low || (sda_oe && !sda_out));
	always #4 clk = ~clk;
	chg_host_model host (.clk(clk), .scl(scl), .sda_low(sda_low), .sda_line(sda_line));
	chg_regbank #(.MS_CYCLES(4), .LONG_PRESS_MS(20), .SHORT_PRESS_MS(5), .OFF_DELAY_MS(20)) dut (
		.clk(clk), .rst_n(rst_n), .scl_in(scl), .sda_in(sda_line), .sda_out(sda_out), .sda_oe(sda_oe),
		.power_button_pin_n(btn_n), .evt(evt), .cfg_q(cfg), .ovp_level_q(ovp), .battery_switch_on_q(on),
		.watchdog_restart_q());
	task automatic wrap_up();
		$display("checks %0d mismatches %0d", num_checks, failures);
		if (failures == 0 && num_checks > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask
	task automatic w(input logic [7:0] r, input logic [7:0] d);
		host.wr(`CHG_SLAVE_ADDR, r, d, ack);
	endtask
	task automatic rchk(input int r, input logic [7:0] e);
		logic [7:0] v;
		host.rd(8'(r), v);
		`CHK("register", e, v)
	endtask
	// One event vector for a single clock, then settle.
	task automatic fire(input logic [15:0] e);
		@(posedge clk);
		evt <= e;
		@(posedge clk);
		evt <= '0;
		repeat (2) @(posedge clk);
	endtask
	initial begin
		repeat (16) @(posedge clk);
		rst_n <= 1'b1;
		repeat (4) @(posedge clk);
		foreach (dft[i]) rchk(i, dft[i]);
		$display("test reset values done");
		for (int i = 0; i < 7; i++) w(8'(i), 8'hff);
		foreach (ones[i]) rchk(i, ones[i]);
		`CHK("ovp", 2'h3, ovp)
		$display("test all ones done");
		fire(16'h8000);
		rchk(2, 8'h4d);
		fire(16'h4000);
		`CHK("switch", 1'b1, on)
		repeat (100) @(posedge clk);
		`CHK("switch", 1'b0, on)
		rchk(2, 8'hcd);
		fire(16'h0200);
		fire(16'h0154);
		rchk(3, 8'h55);
		w(2, 8'h63);
		rchk(2, 8'h61);
		w(2, 8'h81);
		`CHK("switch", 1'b0, on)
		for (int k = 0; k < 4; k++) begin
			w(2, 8'h43);
			`CHK("ovp", 2'h1, ovp)
			fire(16'h0400 << k);
			`CHK("boost", 1'b0, cfg.boost_output_enable)
		end
		host.wr(7'h52, 8'h00, 8'h00, ack);
		`CHK("ack", 1'b0, ack)
		$display("test events done");
		w(0, 8'hc2);
		fire(16'h0002);
		foreach (wd[i]) rchk(i, wd[i]);
		fire(16'h0001);
		foreach (dft[i]) rchk(i, dft[i]);
		$display("test resets done");
		btn_n <= 1'b0;
		repeat (100) @(posedge clk);
		`CHK("switch", 1'b0, on)
		btn_n <= 1'b1;
		repeat (8) @(posedge clk);
		btn_n <= 1'b0;
		repeat (50) @(posedge clk);
		`CHK("switch", 1'b1, on)
		btn_n <= 1'b1;
		w(1, 8'h45);
		btn_n <= 1'b0;
		repeat (100) @(posedge clk);
		`CHK("switch", 1'b1, on)
		btn_n <= 1'b1;
		$display("test button done");
		wrap_up();
	end
	// Cuts a hang short well beyond the expected run length.
	initial begin
		repeat (60000) @(posedge clk);
		failures++;
		wrap_up();
	end
endmodule
